//--- rtl/scl_top.sv
// Serial configuration memory loader with a classic Wishbone
// register slave. Straps and memory data-out come from pins and
// are synchronised here; the memory clock is made from clk_i.
//
// Local design decisions: the placing of the registers and the Wishbone interface to the registers.
`include "scl_regs.svh"
module scl_top import scl_pkg::*; #(
  parameter logic [15:0] CFG_RST = `SCL_CFG_RST,
  parameter logic [15:0] BASE_RST = `SCL_BASE_RST
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Board straps
  input wire logic [2:0] board_slot_strap_i,
  input wire logic rom_present_strap_i,
  // Serial memory pins
  input wire logic rom_do_i,
  output logic rom_cs_o,
  output logic rom_sk_o,
  output logic rom_di_o
);
  localparam logic [3:0] HALF_M1 = 4'(`SCL_SK_HALF_CYC - 1);

  typedef struct packed {
    scl_st_e st;
    logic [2:0] s1_slot;
    logic [2:0] s2_slot;
    logic s1_pres;
    logic s2_pres;
    logic s1_do;
    logic s2_do;
    logic [1:0] boot_cnt;
    logic [2:0] slot;
    logic pres;
    logic [3:0] div;
    logic tick;
    logic busy;
    logic sel;
    logic [12:0] ctrl_hi;
    logic [15:0] cfg;
    logic [15:0] base;
    logic [15:0] ia0;
    logic [15:0] ia1;
    logic [15:0] ia2;
    logic [15:0] ptr;
    logic [15:0] gp;
    logic gpm;
    logic wr;
    logic ewen_pend;
    logic [2:0] idx;
    logic start;
    scl_op_e op;
    logic [5:0] addr;
    logic [15:0] wdata;
    logic ack;
    logic [31:0] dat;
  } scl_top_s;

  scl_top_s r, next_r;
  logic done;
  logic [15:0] rdata;
  logic hit;
  logic [7:0] off;
  logic last;

  // Word address of load/store step idx for a given slot
  function automatic logic [5:0] word_addr(input logic [2:0] idx,
                                           input logic [2:0] slot);
    case (idx)
      3'h0: word_addr = {1'b0, slot, 2'h0}; // R1
      3'h1: word_addr = {1'b0, slot, 2'h1}; // R1
      default: word_addr = `SCL_IA_WORD + 6'(idx - 3'h2); // R2
    endcase
  endfunction

  // Byte-lane merge for 16-bit registers
  function automatic logic [15:0] wmerge(input logic [15:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0] s);
    wmerge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  scl_uwire u_uwire (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(r.tick),
    .start_i(r.start),
    .op_i(r.op),
    .addr_i(r.addr),
    .wdata_i(r.wdata),
    .done_o(done),
    .rdata_o(rdata),
    .do_i(r.s2_do),
    .cs_o(rom_cs_o),
    .sk_o(rom_sk_o),
    .di_o(rom_di_o)
  );

  assign hit = cyc_i && stb_i && !r.ack;
  assign off = {adr_i[7:2], 2'h0};
  assign last = r.gpm || (r.wr ? (r.idx == 3'h1) : (r.idx == 3'h4));

  always_comb begin
    next_r = r;
    next_r.s1_slot = board_slot_strap_i;
    next_r.s2_slot = r.s1_slot;
    next_r.s1_pres = rom_present_strap_i;
    next_r.s2_pres = r.s1_pres;
    next_r.s1_do = rom_do_i;
    next_r.s2_do = r.s1_do;
    next_r.tick = (r.div == HALF_M1);
    next_r.div = next_r.tick ? 4'h0 : r.div + 4'h1;
    next_r.start = 1'b0;
    next_r.ack = hit;
    if (hit) begin
      next_r.dat = 32'h0;
    end

    // Bus reads; a busy block shows only the two trigger bits
    if (hit && !we_i) begin
      if (r.busy) begin
        if (off == `SCL_CTRL_OFF) begin
          next_r.dat[`SCL_RELOAD_BIT] = 1'b1; // R8
          next_r.dat[`SCL_STORE_BIT] = 1'b1; // R8
        end
      end else begin
        case (off)
          `SCL_CTRL_OFF: next_r.dat = {16'h0, r.ctrl_hi, 2'h0, r.sel};
          `SCL_CFG_OFF: next_r.dat = {16'h0, r.cfg};
          `SCL_BASE_OFF: next_r.dat = {16'h0, r.base};
          `SCL_IA01_OFF: next_r.dat = {16'h0, r.ia0};
          `SCL_IA23_OFF: next_r.dat = {16'h0, r.ia1};
          `SCL_IA45_OFF: next_r.dat = {16'h0, r.ia2};
          `SCL_PTR_OFF: next_r.dat = {16'h0, r.ptr};
          `SCL_GP_OFF: next_r.dat = {16'h0, r.gp};
          `SCL_STAT_OFF: next_r.dat = {28'h0, r.pres, r.slot};
          default: next_r.dat = 32'h0;
        endcase
      end
    end

    // Bus writes are dropped while an operation runs
    if (hit && we_i && !r.busy) begin // R9 R10
      case (off)
        `SCL_CTRL_OFF: begin
          if (sel_i[0]) begin
            next_r.sel = dat_i[`SCL_SEL_BIT];
            next_r.ctrl_hi[4:0] = dat_i[7:3];
          end
          if (sel_i[1]) begin
            next_r.ctrl_hi[12:5] = dat_i[15:8];
          end
          if (sel_i[0] && r.pres && r.st == ST_IDLE &&
              (dat_i[`SCL_RELOAD_BIT] || dat_i[`SCL_STORE_BIT])) begin // R11
            // Fetch wins when both triggers are written together
            next_r.busy = 1'b1; // R7
            next_r.gpm = dat_i[`SCL_SEL_BIT]; // R4
            next_r.wr = !dat_i[`SCL_RELOAD_BIT];
            next_r.ewen_pend = !dat_i[`SCL_RELOAD_BIT]; // R15
            next_r.idx = (!dat_i[`SCL_SEL_BIT] && dat_i[`SCL_RELOAD_BIT]
                          && r.slot == `SCL_SLOT_FIXED) ? 3'h2 : 3'h0;
            next_r.st = ST_START;
          end
        end
        `SCL_CFG_OFF: next_r.cfg = wmerge(r.cfg, dat_i, sel_i);
        `SCL_BASE_OFF: next_r.base = wmerge(r.base, dat_i, sel_i);
        `SCL_IA01_OFF: next_r.ia0 = wmerge(r.ia0, dat_i, sel_i);
        `SCL_IA23_OFF: next_r.ia1 = wmerge(r.ia1, dat_i, sel_i);
        `SCL_IA45_OFF: next_r.ia2 = wmerge(r.ia2, dat_i, sel_i);
        `SCL_PTR_OFF: next_r.ptr = wmerge(r.ptr, dat_i, sel_i);
        `SCL_GP_OFF: next_r.gp = wmerge(r.gp, dat_i, sel_i);
        default: ;
      endcase
    end

    case (r.st)
      // Straps settle through the synchronisers before capture
      ST_BOOT: begin
        next_r.boot_cnt = r.boot_cnt + 2'h1;
        if (r.boot_cnt == 2'h3) begin
          next_r.slot = r.s2_slot;
          next_r.pres = r.s2_pres;
          next_r.gpm = 1'b0;
          next_r.wr = 1'b0;
          next_r.ewen_pend = 1'b0;
          next_r.idx = (r.s2_slot == `SCL_SLOT_FIXED) ? 3'h2 : 3'h0; // R13
          next_r.st = r.s2_pres ? ST_START : ST_IDLE; // R10 R11
          next_r.busy = r.s2_pres;
        end
      end
      ST_IDLE: ;
      ST_START: begin
        next_r.start = 1'b1;
        if (r.ewen_pend) begin
          next_r.op = OP_EWEN; // R15
          next_r.addr = `SCL_EWEN_ADDR;
        end else begin
          next_r.op = r.wr ? OP_WR : OP_RD;
          next_r.addr = r.gpm ? r.ptr[5:0] : word_addr(r.idx, r.slot); // R5 R6
        end
        if (r.gpm) begin
          next_r.wdata = r.gp; // R6
        end else begin
          next_r.wdata = (r.idx == 3'h0) ? r.cfg : r.base; // R3
        end
        next_r.st = ST_WAIT;
      end
      ST_WAIT: if (done) begin
        if (r.ewen_pend) begin
          next_r.ewen_pend = 1'b0;
          next_r.st = ST_START;
        end else begin
          if (!r.wr) begin
            if (r.gpm) begin
              next_r.gp = rdata; // R5
            end else begin
              case (r.idx)
                3'h0: next_r.cfg = rdata; // R1
                3'h1: next_r.base = rdata; // R1
                3'h2: next_r.ia0 = rdata; // R2
                3'h3: next_r.ia1 = rdata; // R2
                default: next_r.ia2 = rdata; // R2
              endcase
            end
          end
          if (last) begin
            next_r.busy = 1'b0; // R7
            next_r.st = ST_IDLE;
          end else begin
            next_r.idx = r.idx + 3'h1;
            next_r.st = ST_START;
          end
        end
      end
      default: next_r.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
      r.st <= ST_BOOT;
      r.busy <= 1'b1; // R10
      r.cfg <= CFG_RST;
      r.base <= BASE_RST;
      r.op <= OP_RD;
    end else begin
      r <= next_r;
    end
  end

  assign dat_o = r.dat;
  assign ack_o = r.ack;

  AST_BUSY_READ: assert property (@(posedge clk_i) disable iff (rst_i) // R8
    ($rose(ack_o) && $past(r.busy) && !$past(we_i) &&
     $past(off) == `SCL_CTRL_OFF) |-> dat_o[2:1] == 2'h3)
    else $error("trigger bits not both high while busy");

  AST_BLOCK_RD: assert property (@(posedge clk_i) disable iff (rst_i) // R9
    ($rose(ack_o) && $past(r.busy) && $past(off) != `SCL_CTRL_OFF)
    |-> dat_o == 32'h0)
    else $error("register readable while busy");

  AST_BLOCK_WR: assert property (@(posedge clk_i) disable iff (rst_i) // R9
    (hit && we_i && r.busy && off == `SCL_PTR_OFF)
    |=> $stable(r.ptr))
    else $error("register written while busy");

  AST_BOOT_BUSY: assert property (@(posedge clk_i) disable iff (rst_i) // R10
    $past(rst_i) |-> (r.busy && r.st == ST_BOOT) ##4 (r.busy == r.pres))
    else $error("reset load not busy");

  AST_ABSENT: assert property (@(posedge clk_i) disable iff (rst_i) // R11
    (r.st == ST_IDLE && !r.pres) |=> (!rom_cs_o && !r.busy)[*3])
    else $error("memory touched with no memory present");

  AST_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i) // R7
    (r.st == ST_WAIT && done && !r.ewen_pend && last)
    |=> !r.busy && r.st == ST_IDLE)
    else $error("trigger not cleared at end");

  AST_SLOT7: assert property (@(posedge clk_i) disable iff (rst_i) // R13
    (r.start && !r.gpm && !r.wr && r.slot == `SCL_SLOT_FIXED)
    |-> r.addr[5])
    else $error("slot seven load touched config words");

  AST_CFG_ADDR: assert property (@(posedge clk_i) disable iff (rst_i) // R1
    (r.st == ST_START && !r.gpm && !r.ewen_pend && r.idx == 3'h0)
    |=> r.start && r.addr == {1'b0, r.slot, 2'h0})
    else $error("config word address wrong");

  AST_IA_LOAD: assert property (@(posedge clk_i) disable iff (rst_i) // R2
    (r.st == ST_WAIT && done && !r.wr && !r.gpm && r.idx == 3'h3)
    |=> r.ia1 == $past(rdata))
    else $error("station address word not loaded");

  AST_GP_WR: assert property (@(posedge clk_i) disable iff (rst_i) // R6
    (r.start && r.gpm && r.op == OP_WR)
    |-> (r.wdata == r.gp && r.addr == r.ptr[5:0]))
    else $error("general purpose write mismatch");

  AST_EWEN_FIRST: assert property (@(posedge clk_i) disable iff (rst_i) // R15
    (r.st == ST_IDLE && $past(r.st) == ST_IDLE) ##2 (r.start && r.wr)
    |-> r.op == OP_EWEN)
    else $error("write without write-enable");
endmodule // scl_top

//--- rtl/scl_regs.svh
// Register offsets, field positions, reset values and timing for
// the serial configuration memory loader. Included by the loader, engine and bench.
// Overview of operation
// [R1] Select low: loads take config from word slot*4, base from next word.
// [R2] Select low: loads also fill six station address bytes from three words.
// [R3] Select low: writeback stores config and base into slot-selected words.
// [R4] Low control bits steer the memory and are never loaded or stored.
// [R5] Select high: fetch reads word at pointer low six bits into gp.
// [R6] Select high: writeback writes gp into word at pointer low six bits.
// [R7] Software sets a trigger and polls; device clears it at the end.
// [R8] While busy both trigger bits read back as one.
// [R9] While busy all other bits are neither readable nor writable.
// [R10] The automatic load after reset is busy and blocking too.
// [R11] Memory-present strap low: never touch memory, keep reset defaults.
// [R12] Memory is 64 words of 16 bits, one whole word per access.
// [R13] Slot strap seven: load only station address, keep built-in defaults.
// [R14] Three-wire protocol: start bit, opcode, six-bit address per word.
// [R15] Write-enable before writes; wait for ready before clearing trigger.
`ifndef SCL_REGS_SVH
`define SCL_REGS_SVH
`define SCL_CTRL_OFF 8'h00
`define SCL_CFG_OFF 8'h04
`define SCL_BASE_OFF 8'h08
`define SCL_IA01_OFF 8'h0c
`define SCL_IA23_OFF 8'h10
`define SCL_IA45_OFF 8'h14
`define SCL_PTR_OFF 8'h18
`define SCL_GP_OFF 8'h1c
`define SCL_STAT_OFF 8'h20
`define SCL_SEL_BIT 0
`define SCL_RELOAD_BIT 1
`define SCL_STORE_BIT 2
`define SCL_CFG_RST 16'h0000
`define SCL_BASE_RST 16'h0000
`define SCL_IA_WORD 6'h20
`define SCL_EWEN_ADDR 6'h30
`define SCL_SLOT_FIXED 3'h7
`define SCL_OPC_RD 2'h2
`define SCL_OPC_WR 2'h1
`define SCL_OPC_EWEN 2'h0
`define SCL_CLK_NS 4
`define SCL_SK_PERIOD_NS 64
`define SCL_SK_HALF_CYC (`SCL_SK_PERIOD_NS / `SCL_CLK_NS / 2)
`endif

//--- rtl/scl_pkg.sv
// Types shared by the loader and its serial engine.
// Needs no include file; uses nothing from scl_regs.svh.
package scl_pkg;
  typedef enum logic [2:0] {
    OP_RD = 3'h1, OP_WR = 3'h2, OP_EWEN = 3'h4
  } scl_op_e;
  typedef enum logic [3:0] {
    ST_BOOT = 4'h1, ST_IDLE = 4'h2, ST_START = 4'h4, ST_WAIT = 4'h8
  } scl_st_e;
  typedef enum logic [3:0] {
    UW_IDLE = 4'h1, UW_SHIFT = 4'h2, UW_GAP = 4'h4, UW_POLL = 4'h8
  } scl_uw_e;
  typedef struct packed {
    scl_uw_e st;
    logic [24:0] frame;
    logic [4:0] cnt;
    logic [4:0] len;
    logic wr;
    logic cs;
    logic sk;
    logic di;
    logic done;
    logic [15:0] rdata;
  } scl_uw_s;
endpackage

//--- rtl/scl_uwire.sv
// Three-wire serial memory engine: one word read, write or
// write-enable per start pulse. Expects a half-bit tick and a
// data-out line already synchronised to clk_i.
`include "scl_regs.svh"
module scl_uwire import scl_pkg::*; (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Command side
  input wire logic tick_i,
  input wire logic start_i,
  input scl_op_e op_i,
  input wire logic [5:0] addr_i,
  input wire logic [15:0] wdata_i,
  output logic done_o,
  output logic [15:0] rdata_o,
  // Memory pins
  input wire logic do_i,
  output logic cs_o,
  output logic sk_o,
  output logic di_o
);
  scl_uw_s r, next_r;
  logic [1:0] opc;

  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    case (op_i)
      OP_RD: opc = `SCL_OPC_RD;
      OP_WR: opc = `SCL_OPC_WR;
      default: opc = `SCL_OPC_EWEN;
    endcase
    case (r.st)
      UW_IDLE: if (start_i) begin
        next_r.frame = {1'b1, opc, addr_i, wdata_i}; // R14 R12
        next_r.len = (op_i == OP_EWEN) ? 5'h08 : 5'h18;
        next_r.wr = (op_i == OP_WR);
        next_r.cnt = 5'h00;
        next_r.cs = 1'b1;
        next_r.sk = 1'b0;
        next_r.di = 1'b1;
        next_r.st = UW_SHIFT;
      end
      UW_SHIFT: if (tick_i) begin
        if (!r.sk) begin
          next_r.sk = 1'b1;
        end else begin
          // Sample on the falling edge, well after memory drove it
          next_r.sk = 1'b0;
          next_r.rdata = {r.rdata[14:0], do_i};
          next_r.frame = {r.frame[23:0], 1'b0};
          next_r.di = r.frame[23];
          if (r.cnt == r.len) begin
            next_r.di = 1'b0;
            next_r.st = UW_GAP;
          end else begin
            next_r.cnt = r.cnt + 5'h01;
          end
        end
      end
      UW_GAP: if (tick_i) begin
        if (r.cs) begin
          next_r.cs = 1'b0;
        end else if (r.wr) begin
          next_r.cs = 1'b1; // R15
          next_r.st = UW_POLL;
        end else begin
          next_r.done = 1'b1;
          next_r.st = UW_IDLE;
        end
      end
      // No timeout: a memory that never reports ready hangs here
      UW_POLL: if (tick_i && do_i) begin
        next_r.cs = 1'b0;
        next_r.done = 1'b1; // R15
        next_r.st = UW_IDLE;
      end
      default: next_r.st = UW_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
      r.st <= UW_IDLE;
    end else begin
      r <= next_r;
    end
  end

  assign done_o = r.done;
  assign rdata_o = r.rdata;
  assign cs_o = r.cs;
  assign sk_o = r.sk;
  assign di_o = r.di;
endmodule // scl_uwire

//--- verification/scl_mem_model.sv
// Behavioural 64x16 three-wire serial memory for the loader bench.
// Assumes the device latches on sk rise and samples on sk fall.
module scl_mem_model (
  // Memory pins
  input wire logic cs_i,
  input wire logic sk_i,
  input wire logic di_i,
  output logic do_o,
  // Bench control
  input wire logic slow_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [64];
  logic [8:0] hdr;
  logic [15:0] sh;
  logic wen = 0, busy = 0, dv = 0, junk = 0;
  int n = 0, frames = 0, bad = 0;
  // Released line wanders so stale data is never trusted
  always #3 junk = ~junk;
  assign do_o = !cs_i ? junk : (n == 0 ? !busy : dv);
  always @(posedge cs_i) n = 0;
  always @(posedge busy) #(slow_i ? 800 : 60) busy = 0;
  always @(posedge sk_i) if (cs_i && n < 25) begin
    n++;
    if (n <= 9) hdr = {hdr[7:0], di_i};
    if (n == 9) begin
      frames++;
      dv = 1'b0;
      if (!hdr[8]) bad++;
      if (hdr[7:4] == 4'b0011) wen = 1;
    end else if (n > 9) begin
      sh = {sh[14:0], di_i};
      if (hdr[7:6] == 2'b10) dv = mem[hdr[5:0]][25 - n];
    end
    if (n == 25 && hdr[7:6] == 2'b01) begin
      if (wen) mem[hdr[5:0]] = sh;
      else bad++;
      busy = 1;
    end
  end
endmodule // scl_mem_model

//--- verification/test_scl_top.sv
// Self-checking bench for scl_top: Wishbone host on one side,
// behavioural serial memory on the other. Needs scl_regs.svh.
`include "scl_regs.svh"
module test_scl_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] CFG_D = 16'h1c3a;
  localparam logic [15:0] BASE_D = 16'h0e71;
  logic clk_i, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ack_o;
  logic want = 0, slow = 0, pres = 1, cs, sk, di, dout;
  logic [7:0] adr_i = 0;
  logic [3:0] sel_i = 4'h3;
  logic [31:0] dat_i = 0, dat_o, rdat;
  logic [2:0] slot = 0, s0;
  logic [15:0] r;
  logic [5:0] a;
  int err_count = 0, check_count = 0, n0;
  logic [31:0] exp_q[$];
  string nm_q[$];
  scl_top #(.CFG_RST(CFG_D), .BASE_RST(BASE_D)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .board_slot_strap_i(slot),
    .rom_present_strap_i(pres), .rom_do_i(dout), .rom_cs_o(cs),
    .rom_sk_o(sk), .rom_di_o(di));
  scl_mem_model m_u (.cs_i(cs), .sk_i(sk), .di_i(di), .do_o(dout),
    .slow_i(slow));
  task automatic chk(input string n, input logic [31:0] e, s);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] ad,
                     input logic [15:0] d, input logic c);
    @(posedge clk_i);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= ad;
    dat_i <= {16'h0, d};
    want <= c;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rdat = dat_o;
    cyc_i <= 0;
    stb_i <= 0;
    want <= 0;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] e,
                    input string n);
    exp_q.push_back(e);
    nm_q.push_back(n);
    bus(0, ad, 16'h0, 1);
  endtask
  task automatic wr(input logic [7:0] ad, input logic [15:0] d);
    bus(1, ad, d, 0);
  endtask
  task automatic poll;
    do bus(0, `SCL_CTRL_OFF, 16'h0, 0);
    while (rdat[2:1] !== 2'b00);
  endtask
  task automatic boot(input logic [2:0] s, input logic p);
    @(posedge clk_i);
    slot <= s;
    pres <= p;
    rst_i <= 1;
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
  endtask
  task automatic fill;
    foreach (m_u.mem[i]) m_u.mem[i] = 16'($urandom);
  endtask
  task automatic loaded(input logic [2:0] s);
    rd(`SCL_CFG_OFF, {16'h0, s == 7 ? CFG_D : m_u.mem[{s, 2'b00}]},
       "config");
    rd(`SCL_BASE_OFF, {16'h0, s == 7 ? BASE_D : m_u.mem[{s, 2'b01}]},
       "base");
    for (int i = 0; i < 3; i++)
      rd(`SCL_IA01_OFF + 8'(4 * i), {16'h0, m_u.mem[6'h20 + 6'(i)]},
         "station");
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk_i)
    if (ack_o === 1'b1 && want && exp_q.size() > 0)
      chk(nm_q.pop_front(), exp_q.pop_front(), dat_o);
  initial begin
    clk_i = 0;
    forever #2 clk_i = ~clk_i;
  end
  // Whole run needs about 10k cycles
  initial begin
    #200000;
    err_count++;
    summarize();
  end
  initial begin
    void'($urandom(32));
    fill();
    s0 = 3'($urandom_range(6));
    boot(s0, 1);
    rd(`SCL_CTRL_OFF, 32'h6, "ctrl boot");
    rd(`SCL_CFG_OFF, 32'h0, "blocked");
    poll();
    loaded(s0);
    rd(`SCL_STAT_OFF, {28'h0, 1'b1, s0}, "status");
    $display("test boot done");
    fill();
    wr(`SCL_CTRL_OFF, 16'h5a52);
    rd(`SCL_CTRL_OFF, 32'h6, "ctrl fetch");
    poll();
    loaded(s0);
    rd(`SCL_CTRL_OFF, 32'h5a50, "ctrl upper");
    $display("test fetch done");
    slow <= 1;
    r = 16'($urandom);
    wr(`SCL_CFG_OFF, r);
    wr(`SCL_BASE_OFF, ~r);
    wr(`SCL_CTRL_OFF, 16'h0004);
    rd(`SCL_CTRL_OFF, 32'h6, "ctrl store");
    poll();
    chk("store cfg", {16'h0, r}, {16'h0, m_u.mem[{s0, 2'b00}]});
    chk("store base", {16'h0, ~r}, {16'h0, m_u.mem[{s0, 2'b01}]});
    chk("ready", 32'h0, {31'h0, m_u.busy});
    chk("unenabled", 32'h0, 32'(m_u.bad));
    $display("test store done");
    for (int i = 0; i < 2; i++) begin
      a = i ? 6'h3f : 6'h00;
      r = 16'($urandom);
      slow <= i[0];
      wr(`SCL_PTR_OFF, {10'($urandom), a});
      wr(`SCL_GP_OFF, r);
      wr(`SCL_CTRL_OFF, 16'h0005);
      poll();
      chk("gp store", {16'h0, r}, {16'h0, m_u.mem[a]});
      m_u.mem[a ^ 6'h15] = ~r;
      wr(`SCL_PTR_OFF, {10'h0, a ^ 6'h15});
      wr(`SCL_CTRL_OFF, 16'h0003);
      wr(`SCL_PTR_OFF, 16'h0);
      poll();
      rd(`SCL_GP_OFF, {16'h0, ~r}, "gp fetch");
      rd(`SCL_PTR_OFF, {26'h0, a ^ 6'h15}, "ptr kept");
    end
    // Both triggers together: fetch must win, memory left alone
    r = 16'($urandom);
    m_u.mem[6'h2c] = r;
    wr(`SCL_PTR_OFF, 16'h002c);
    wr(`SCL_CTRL_OFF, 16'h0007);
    poll();
    rd(`SCL_GP_OFF, {16'h0, r}, "both fetch");
    chk("both kept", {16'h0, r}, {16'h0, m_u.mem[6'h2c]});
    rd(8'h24, 32'h0, "unmapped");
    $display("test general done");
    fill();
    boot(3'h7, 1);
    poll();
    loaded(3'h7);
    $display("test slot done");
    n0 = m_u.frames;
    boot(3'($urandom), 0);
    poll();
    wr(`SCL_CTRL_OFF, 16'h0002);
    rd(`SCL_CTRL_OFF, 32'h0, "no op");
    rd(`SCL_CFG_OFF, {16'h0, CFG_D}, "cfg default");
    rd(`SCL_BASE_OFF, {16'h0, BASE_D}, "base default");
    chk("frames", 32'(n0), 32'(m_u.frames));
    $display("test absent done");
    repeat (2) @(posedge clk_i);
    summarize();
  end
endmodule // test_scl_top
